// ===== hw/agcc_core.sv
// agcc_core: per half-bridge pre-charge / pre-discharge sequencing and current adaptation
// assumes control bits come from same-clock register logic; pwm pin and gate comparators async
// Operation
// - adapt only while gate_adapt_select is 10 or 11
// - tune pre-charge to turn-on target, pre-discharge to turn-off target
// - turn-on and turn-off targets come from writable control inputs
// - measure turn-on and turn-off delays and present them as status
// - source adaptive pre-charge current for the configured pre-charge time
// - sink adaptive pre-discharge current for the configured pre-discharge time
// - adaptive currents never exceed the per-bridge maximum drive current unless that maximum is below CUR_MIN
// - adaptive currents never fall below the lowest current step
// - starting currents come from the configured initial values
// - charge, discharge and freewheel phases use their configured currents
// - hard-off uses the top discharge code 63
// - pre-charge and pre-discharge durations are set per half-bridge
// - hold current chosen by a control bit outside switching phases
// - pwm pin is synchronised before the internal pwm changes
// - on pwm enable, initialise currents to the init value clamped into [CUR_MIN, maximum]
// - unfiltered: raise current when delay too long, lower when too short
// - step size one when step bit is 0, two when 1
// - filtered: change only when last two cycles erred the same way
module agcc_core
    import agcc_pkg::*;
#(
    parameter int NUM_HB = 2
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // general control
    input wire logic [1:0] gate_adapt_select,
    input wire logic adapt_filter_enable,
    input wire logic adapt_step_size,
    input wire logic hold_current_sel,
    // per half-bridge control
    input wire logic [NUM_HB-1:0] bridge_pwm_enable,
    input wire agcc_cfg_t hb_cfg [NUM_HB],
    // external pwm pin and gate threshold comparators
    input wire logic pwm_input_pin,
    input wire logic [NUM_HB-1:0] gate_on_reached,
    input wire logic [NUM_HB-1:0] gate_off_reached,
    // gate drive and status
    output agcc_drv_t hb_drive [NUM_HB],
    output agcc_stat_t measured_delay_status [NUM_HB]
);

    if (NUM_HB < 1) begin : g_bad_num
        $error("agcc_core: NUM_HB must be at least 1");
    end

    // clamp a widened value into [CUR_MIN, maxc]
    function automatic logic [CUR_W-1:0] clamp_cur(input logic [CUR_W+1:0] v,
                                                   input logic [CUR_W-1:0] maxc);
        logic [CUR_W+1:0] r;
        r = v;
        if (r > {2'b00, maxc}) begin
            r = {2'b00, maxc};
        end
        if (r < {2'b00, CUR_MIN}) begin
            r = {2'b00, CUR_MIN};
        end
        return r[CUR_W-1:0];
    endfunction

    // one adaptation step in the given direction, clamped
    function automatic logic [CUR_W-1:0] adapt_cur(input logic [CUR_W-1:0] cur,
                                                   input agcc_err_t err,
                                                   input logic [CUR_W-1:0] step,
                                                   input logic [CUR_W-1:0] maxc);
        logic [CUR_W+1:0] v;
        v = {2'b00, cur};
        if (err == ERR_LONG) begin
            v = {2'b00, cur} + {2'b00, step};
        end else if (err == ERR_SHORT) begin
            v = (cur > step) ? {2'b00, cur - step} : '0;
        end
        return clamp_cur(v, maxc);
    endfunction

    // compare a measured delay with its target
    function automatic agcc_err_t delay_err(input logic [DLY_W-1:0] meas,
                                            input logic [DLY_W-1:0] target);
        if (meas > target) begin
            return ERR_LONG;
        end else if (meas < target) begin
            return ERR_SHORT;
        end
        return ERR_NONE;
    endfunction

    // filter: pass the error only if it repeats the previous one
    function automatic agcc_err_t filt_err(input agcc_err_t cur, input agcc_err_t prev,
                                           input logic filt_en);
        if (!filt_en) begin
            return cur;
        end
        return (cur == prev) ? cur : ERR_NONE;
    endfunction

    // pwm pin synchroniser
    logic pwm_meta_ff;
    logic pwm_sync_ff;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pwm_meta_ff <= 1'b0;
            pwm_sync_ff <= 1'b0;
        end else begin
            pwm_meta_ff <= pwm_input_pin;
            pwm_sync_ff <= pwm_meta_ff;
        end
    end

    // shared decode
    wire adapt_on = gate_adapt_select[AGC_ADAPT_BIT];
    wire prephase_on = (gate_adapt_select != AGC_OFF);
    wire fixed_on = (gate_adapt_select == AGC_FIXED);
    wire [CUR_W-1:0] step = adapt_step_size ? STEP_TWO : STEP_ONE;
    wire [CUR_W-1:0] hold_code = hold_current_sel ? HOLD_HIGH : HOLD_LOW;

    for (genvar i = 0; i < NUM_HB; i++) begin : g_hb
        logic on_meta_ff;
        logic on_sync_ff;
        logic off_meta_ff;
        logic off_sync_ff;
        logic en_ff;
        agcc_state_t state_ff;
        agcc_state_t nxt_state;
        logic [TIME_W-1:0] phase_ff;
        logic [TIME_W-1:0] nxt_phase;
        logic [DLY_W-1:0] meas_ff;
        logic [DLY_W-1:0] nxt_meas;
        logic [CUR_W-1:0] pchg_ff;
        logic [CUR_W-1:0] pdchg_ff;
        agcc_err_t on_prev_ff;
        agcc_err_t off_prev_ff;
        agcc_drv_t drv_ff;
        agcc_drv_t nxt_drv;
        agcc_stat_t stat_ff;

        // gate comparator synchronisers
        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                on_meta_ff <= 1'b0;
                on_sync_ff <= 1'b0;
                off_meta_ff <= 1'b0;
                off_sync_ff <= 1'b0;
            end else begin
                on_meta_ff <= gate_on_reached[i];
                on_sync_ff <= on_meta_ff;
                off_meta_ff <= gate_off_reached[i];
                off_sync_ff <= off_meta_ff;
            end
        end

        wire en = bridge_pwm_enable[i];
        wire en_rise = en & ~en_ff;
        wire [CUR_W-1:0] maxc = hb_cfg[i].max_drive_current;
        wire [CUR_W-1:0] pchg_init = clamp_cur({2'b00, hb_cfg[i].precharge_init_value},
                                               maxc);
        wire [CUR_W-1:0] pdchg_init = clamp_cur({2'b00, hb_cfg[i].predischarge_init_value},
                                                maxc);
        wire [CUR_W-1:0] pchg_lvl = fixed_on ? pchg_init : pchg_ff;
        wire [CUR_W-1:0] pdchg_lvl = fixed_on ? pdchg_init : pdchg_ff;
        wire meas_sat = (meas_ff == DLY_MAX);
        wire phase_end = (phase_ff <= TIME_ONE);
        wire on_done = (state_ff == ST_CHG) && (on_sync_ff || meas_sat);
        wire off_done = (state_ff == ST_DCHG) && (off_sync_ff || meas_sat);
        wire [DLY_W-1:0] meas_now = meas_sat ? DLY_MAX : meas_ff + DLY_ONE;
        wire agcc_err_t on_err = delay_err(meas_now, hb_cfg[i].turn_on_target);
        wire agcc_err_t off_err = delay_err(meas_now, hb_cfg[i].turn_off_target);
        wire agcc_err_t on_eff = filt_err(on_err, on_prev_ff, adapt_filter_enable);
        wire agcc_err_t off_eff = filt_err(off_err, off_prev_ff, adapt_filter_enable);

        // phase sequencing
        always_comb begin
            nxt_state = state_ff;
            nxt_phase = phase_ff;
            nxt_meas = meas_ff;
            unique case (state_ff)
                ST_OFF_HOLD: begin
                    if (en && pwm_sync_ff) begin
                        nxt_meas = '0;
                        nxt_phase = hb_cfg[i].precharge_time;
                        nxt_state = (prephase_on && hb_cfg[i].precharge_time != TIME_ZERO)
                                    ? ST_PRECHG : ST_CHG;
                    end
                end
                ST_PRECHG: begin
                    nxt_meas = meas_sat ? meas_ff : meas_now;
                    nxt_phase = phase_ff - TIME_ONE;
                    if (phase_end) begin
                        nxt_state = ST_CHG;
                    end
                end
                ST_CHG: begin
                    nxt_meas = meas_sat ? meas_ff : meas_now;
                    if (on_done) begin
                        nxt_state = ST_ON_HOLD;
                    end
                end
                ST_ON_HOLD: begin
                    if (!pwm_sync_ff) begin
                        nxt_meas = '0;
                        nxt_phase = hb_cfg[i].predischarge_time;
                        nxt_state = (prephase_on && hb_cfg[i].predischarge_time != TIME_ZERO)
                                    ? ST_PREDCHG : ST_DCHG;
                    end
                end
                ST_PREDCHG: begin
                    nxt_meas = meas_sat ? meas_ff : meas_now;
                    nxt_phase = phase_ff - TIME_ONE;
                    if (phase_end) begin
                        nxt_state = ST_DCHG;
                    end
                end
                ST_DCHG: begin
                    nxt_meas = meas_sat ? meas_ff : meas_now;
                    if (off_done) begin
                        nxt_state = ST_OFF_HOLD;
                    end
                end
                default: begin
                    nxt_state = ST_OFF_HOLD;
                end
            endcase
            if (!en) begin
                nxt_state = ST_OFF_HOLD;
            end
        end

        // gate drive for the coming phase
        always_comb begin
            nxt_drv = '0;
            unique case (nxt_state)
                ST_OFF_HOLD: begin
                    nxt_drv = '{hold_code, 1'b1, hb_cfg[i].freewheel_current, 1'b0};
                end
                ST_PRECHG: begin
                    nxt_drv = '{pchg_lvl, 1'b0, hb_cfg[i].freewheel_current, 1'b1};
                end
                ST_CHG: begin
                    nxt_drv = '{hb_cfg[i].charge_current, 1'b0,
                                hb_cfg[i].freewheel_current, 1'b1};
                end
                ST_ON_HOLD: begin
                    nxt_drv = '{hold_code, 1'b0, hold_code, 1'b1};
                end
                ST_PREDCHG: begin
                    nxt_drv = '{pdchg_lvl, 1'b1, hold_code, 1'b1};
                end
                ST_DCHG: begin
                    nxt_drv = '{hb_cfg[i].discharge_current, 1'b1, hold_code, 1'b1};
                end
                default: begin
                    nxt_drv = '0;
                end
            endcase
            if (!en) begin
                nxt_drv = '{CUR_HARD_OFF, 1'b1, CUR_HARD_OFF, 1'b1};
            end
        end

        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                en_ff <= 1'b0;
                state_ff <= ST_OFF_HOLD;
                phase_ff <= '0;
                meas_ff <= '0;
                drv_ff <= '{CUR_HARD_OFF, 1'b1, CUR_HARD_OFF, 1'b1};
            end else begin
                en_ff <= en;
                state_ff <= nxt_state;
                phase_ff <= nxt_phase;
                meas_ff <= nxt_meas;
                drv_ff <= nxt_drv;
            end
        end

        // adaptation, once per measured edge
        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                pchg_ff <= CUR_MIN;
                pdchg_ff <= CUR_MIN;
                on_prev_ff <= ERR_NONE;
                off_prev_ff <= ERR_NONE;
                stat_ff <= '{'0, '0, CUR_MIN, CUR_MIN};
            end else begin
                if (en_rise) begin
                    pchg_ff <= pchg_init;
                    pdchg_ff <= pdchg_init;
                    on_prev_ff <= ERR_NONE;
                    off_prev_ff <= ERR_NONE;
                end else begin
                    if (on_done) begin
                        stat_ff.turn_on_delay <= meas_now;
                        on_prev_ff <= on_err;
                        if (adapt_on) begin
                            pchg_ff <= adapt_cur(pchg_ff, on_eff, step,
                                                 maxc);
                        end
                    end
                    if (off_done) begin
                        stat_ff.turn_off_delay <= meas_now;
                        off_prev_ff <= off_err;
                        if (adapt_on) begin
                            pdchg_ff <= adapt_cur(pdchg_ff, off_eff, step,
                                                  maxc);
                        end
                    end
                end
                stat_ff.adaptive_precharge_current <= pchg_ff;
                stat_ff.adaptive_predischarge_current <= pdchg_ff;
            end
        end

        assign hb_drive[i] = drv_ff;
        assign measured_delay_status[i] = stat_ff;
    end

endmodule // agcc_core

// ===== hw/agcc_pkg.sv
// agcc_pkg: constants, codes and carrier types of the adaptive gate current control
// assumes one 10 MHz bridge-driver clock; current codes count 0.5 mA steps
package agcc_pkg;
    localparam int CUR_W = 6;
    localparam int TIME_W = 8;
    localparam int DLY_W = 8;
    // current codes
    localparam logic [CUR_W-1:0] CUR_MIN = 6'h01;
    localparam logic [CUR_W-1:0] CUR_HARD_OFF = 6'h3F;
    localparam logic [CUR_W-1:0] HOLD_LOW = 6'h01;
    localparam logic [CUR_W-1:0] HOLD_HIGH = 6'h04;
    localparam logic [CUR_W-1:0] STEP_ONE = 6'h01;
    localparam logic [CUR_W-1:0] STEP_TWO = 6'h02;
    // delay measurement saturation and step; phase timer step and zero
    localparam logic [DLY_W-1:0] DLY_MAX = 8'hFF;
    localparam logic [DLY_W-1:0] DLY_ONE = 8'h01;
    localparam logic [TIME_W-1:0] TIME_ONE = 8'h01;
    localparam logic [TIME_W-1:0] TIME_ZERO = 8'h00;
    // gate_adapt_select codes
    localparam logic [1:0] AGC_OFF = 2'h0;
    localparam logic [1:0] AGC_FIXED = 2'h1;
    localparam int AGC_ADAPT_BIT = 1;
    // delay error direction
    typedef enum logic [1:0] {
        ERR_NONE = 2'b00,
        ERR_LONG = 2'b01,
        ERR_SHORT = 2'b10
    } agcc_err_t;
    // per half-bridge phase
    typedef enum logic [2:0] {
        ST_OFF_HOLD = 3'b000,
        ST_PRECHG = 3'b001,
        ST_CHG = 3'b010,
        ST_ON_HOLD = 3'b011,
        ST_PREDCHG = 3'b100,
        ST_DCHG = 3'b101
    } agcc_state_t;
    // per half-bridge configuration
    typedef struct packed {
        logic [DLY_W-1:0] turn_on_target;
        logic [DLY_W-1:0] turn_off_target;
        logic [CUR_W-1:0] max_drive_current;
        logic [CUR_W-1:0] precharge_init_value;
        logic [CUR_W-1:0] predischarge_init_value;
        logic [TIME_W-1:0] precharge_time;
        logic [TIME_W-1:0] predischarge_time;
        logic [CUR_W-1:0] charge_current;
        logic [CUR_W-1:0] discharge_current;
        logic [CUR_W-1:0] freewheel_current;
    } agcc_cfg_t;
    // gate drive command; sink high means current drawn from the gate
    typedef struct packed {
        logic [CUR_W-1:0] act_code;
        logic act_sink;
        logic [CUR_W-1:0] fw_code;
        logic fw_sink;
    } agcc_drv_t;
    // readable status
    typedef struct packed {
        logic [DLY_W-1:0] turn_on_delay;
        logic [DLY_W-1:0] turn_off_delay;
        logic [CUR_W-1:0] adaptive_precharge_current;
        logic [CUR_W-1:0] adaptive_predischarge_current;
    } agcc_stat_t;
endpackage

// ===== sim/agcc_core_props.sv
// agcc_core_props: port-level checks of the adaptive gate current control
// assumes a bind to agcc_core; mode and filter change only while bridges are disabled
module agcc_core_props
    import agcc_pkg::*;
#(
    parameter int NUM_HB = 2
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // control
    input wire logic [1:0] gate_adapt_select,
    input wire logic adapt_filter_enable,
    input wire logic adapt_step_size,
    input wire logic hold_current_sel,
    input wire logic [NUM_HB-1:0] bridge_pwm_enable,
    input wire agcc_cfg_t hb_cfg [NUM_HB],
    // pins
    input wire logic pwm_input_pin,
    input wire logic [NUM_HB-1:0] gate_on_reached,
    input wire logic [NUM_HB-1:0] gate_off_reached,
    // outputs
    input wire agcc_drv_t hb_drive [NUM_HB],
    input wire agcc_stat_t measured_delay_status [NUM_HB]
);
    logic [2:0] run_ff;
    wire [CUR_W-1:0] pchg = measured_delay_status[0].adaptive_precharge_current;
    wire [CUR_W-1:0] pdchg = measured_delay_status[0].adaptive_predischarge_current;
    wire [CUR_W-1:0] maxc = hb_cfg[0].max_drive_current;
    wire [CUR_W-1:0] initc = hb_cfg[0].precharge_init_value;
    wire [CUR_W-1:0] init_exp = (initc > maxc) ? maxc : initc;
    wire [CUR_W-1:0] hold_exp = hold_current_sel ? HOLD_HIGH : HOLD_LOW;
    wire settled = run_ff == 3'h4;
    wire off_hold = settled && hb_drive[0].act_sink && hb_drive[0].act_code == hold_exp;
    // cycles since bridge 0 was enabled, saturating
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            run_ff <= 3'h0;
        end else if (!bridge_pwm_enable[0]) begin
            run_ff <= 3'h0;
        end else if (!settled) begin
            run_ff <= run_ff + 3'h1;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_hard_off_b0: assert property (!bridge_pwm_enable[0] |=>
        hb_drive[0] == {CUR_HARD_OFF, 1'b1, CUR_HARD_OFF, 1'b1})
        else $error("bridge 0 not hard off");
    a_hard_off_b1: assert property (!bridge_pwm_enable[1] |=>
        hb_drive[1] == {CUR_HARD_OFF, 1'b1, CUR_HARD_OFF, 1'b1})
        else $error("bridge 1 not hard off");
    a_pchg_max: assert property (settled |-> pchg <= maxc)
        else $error("pre-charge current above maximum");
    a_pdchg_max: assert property (settled |-> pdchg <= maxc)
        else $error("pre-discharge current above maximum");
    a_cur_floor: assert property (pchg >= CUR_MIN && pdchg >= CUR_MIN)
        else $error("adaptive current below lowest step");
    a_init_load: assert property ($rose(bridge_pwm_enable[0])
        && gate_adapt_select != AGC_OFF |-> ##[1:3] pchg == init_exp)
        else $error("pre-charge start value wrong");
    a_step_one: assert property (settled && !adapt_step_size && $changed(pchg)
        |-> pchg == $past(pchg) + STEP_ONE || pchg == $past(pchg) - STEP_ONE)
        else $error("single step exceeded");
    a_fixed_mode: assert property (settled && !gate_adapt_select[1]
        |-> $stable(pchg) && $stable(pdchg)) else $error("current adapted outside adaptive mode");
    a_sync_wait: assert property ($rose(pwm_input_pin) && off_hold
        && bridge_pwm_enable[0] |=> $stable(hb_drive[0]) ##1 $stable(hb_drive[0]))
        else $error("drive reacted before pwm synchronisation");
    c_adapt: cover property (settled && gate_adapt_select[1] && $changed(pchg));
    c_enable: cover property ($rose(bridge_pwm_enable[0]));
    c_filter: cover property (settled && adapt_filter_enable && $changed(pdchg));
endmodule // agcc_core_props

bind agcc_core agcc_core_props #(.NUM_HB(NUM_HB)) i_agcc_core_props (
    .ref_clk(ref_clk), .nrst(nrst), .gate_adapt_select(gate_adapt_select),
    .adapt_filter_enable(adapt_filter_enable), .adapt_step_size(adapt_step_size),
    .hold_current_sel(hold_current_sel), .bridge_pwm_enable(bridge_pwm_enable),
    .hb_cfg(hb_cfg), .pwm_input_pin(pwm_input_pin), .gate_on_reached(gate_on_reached),
    .gate_off_reached(gate_off_reached), .hb_drive(hb_drive),
    .measured_delay_status(measured_delay_status));

// ===== sim/agcc_gate_model.sv
// agcc_gate_model: external mosfet gate as a charge bucket with two comparator thresholds
// assumes one drive command per clock; comparator outputs change on the clock
module agcc_gate_model
    import agcc_pkg::*;
#(
    parameter int ON_TH = 100,
    parameter int OFF_TH = 20
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // drive in, comparators out
    input wire agcc_drv_t drv,
    output logic on_reached,
    output logic off_reached
);
    int level;
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            level = 0;
        end else begin
            level = drv.act_sink ? level - int'(drv.act_code) : level + int'(drv.act_code);
        end
        level = (level < 0) ? 0 : (level > 200) ? 200 : level;
        on_reached <= level >= ON_TH;
        off_reached <= level <= OFF_TH;
    end
endmodule // agcc_gate_model

// ===== sim/tb_top.sv
// tb_top: directed scenarios for agcc_core with a gate model on each bridge
// assumes the design's hand-over timing; inputs move on the falling clock edge
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import agcc_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] gate_adapt_select = 2'h0;
    logic adapt_filter_enable = 1'b0;
    logic adapt_step_size = 1'b0;
    logic hold_current_sel = 1'b0;
    logic [1:0] bridge_pwm_enable = 2'h0;
    logic pwm_input_pin = 1'b0;
    agcc_cfg_t cfg = '{8'h01, 8'hFE, 6'h0C, 6'h14, 6'h03, 8'h06, 8'h06, 6'h08, 6'h14, 6'h05};
    agcc_cfg_t hb_cfg [2];
    logic [1:0] gate_on_reached;
    logic [1:0] gate_off_reached;
    agcc_drv_t hb_drive [2];
    agcc_stat_t measured_delay_status [2];
    agcc_drv_t drv_on;
    agcc_drv_t drv_off;
    int n_fail = 0;
    int n_checks = 0;
    int cycles = 0;
    assign hb_cfg[0] = cfg;
    assign hb_cfg[1] = cfg;
    always #50 ref_clk = ~ref_clk;
    agcc_core #(.NUM_HB(2)) i_agcc_core (
        .ref_clk(ref_clk), .nrst(nrst), .gate_adapt_select(gate_adapt_select),
        .adapt_filter_enable(adapt_filter_enable), .adapt_step_size(adapt_step_size),
        .hold_current_sel(hold_current_sel), .bridge_pwm_enable(bridge_pwm_enable),
        .hb_cfg(hb_cfg), .pwm_input_pin(pwm_input_pin), .gate_on_reached(gate_on_reached),
        .gate_off_reached(gate_off_reached), .hb_drive(hb_drive),
        .measured_delay_status(measured_delay_status));
    for (genvar k = 0; k < 2; k++) begin : g_gate
        agcc_gate_model i_agcc_gate_model (.ref_clk(ref_clk), .nrst(nrst), .drv(hb_drive[k]),
            .on_reached(gate_on_reached[k]), .off_reached(gate_off_reached[k]));
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic cur_check(input logic [5:0] p, input logic [5:0] d);
        check(16'(measured_delay_status[0].adaptive_precharge_current), 16'(p));
        check(16'(measured_delay_status[0].adaptive_predischarge_current), 16'(d));
    endtask
    // one pwm period; drive sampled early in each half
    task automatic pulse();
        pwm_input_pin = 1'b1;
        tick(5);
        drv_on = hb_drive[0];
        tick(55);
        pwm_input_pin = 1'b0;
        tick(5);
        drv_off = hb_drive[0];
        tick(55);
    endtask
    task automatic set_mode(input logic [1:0] sel, input logic filt);
        bridge_pwm_enable = 2'h0;
        tick(2);
        gate_adapt_select = sel;
        adapt_filter_enable = filt;
        tick(1);
        bridge_pwm_enable = 2'h3;
        tick(4);
    endtask
    task automatic t_reset();
        check(16'(hb_drive[0]), {2'h0, CUR_HARD_OFF, 1'b1, CUR_HARD_OFF, 1'b1});
        cur_check(CUR_MIN, CUR_MIN);
        check(16'(measured_delay_status[0].turn_on_delay), 16'h0000);
    endtask
    task automatic t_enable_hold();
        set_mode(2'h2, 1'b0);
        cur_check(6'h0C, 6'h03);
        check(16'(measured_delay_status[1].adaptive_precharge_current), 16'h000C);
        check(16'(hb_drive[0]), {2'h0, HOLD_LOW, 1'b1, 6'h05, 1'b0});
        hold_current_sel = 1'b1;
        tick(2);
        check(16'(hb_drive[0].act_code), 16'(HOLD_HIGH));
        check(16'(hb_drive[0].act_sink), 16'h0001);
        hold_current_sel = 1'b0;
        tick(2);
    endtask
    task automatic t_adapt();
        pulse();
        check(16'(drv_on), {2'h0, 6'h0C, 1'b0, 6'h05, 1'b1});
        check(16'({drv_off.act_code, drv_off.act_sink}), 16'h0007);
        check(16'(measured_delay_status[0].turn_on_delay), 16'h000D);
        check(16'(measured_delay_status[0].turn_off_delay), 16'h0010);
        cur_check(6'h0C, 6'h02);
        pulse();
        pulse();
        cur_check(6'h0C, CUR_MIN);
        cfg.turn_on_target = 8'hFE;
        pulse();
        cur_check(6'h0B, CUR_MIN);
        adapt_step_size = 1'b1;
        pulse();
        cur_check(6'h09, CUR_MIN);
        adapt_step_size = 1'b0;
    endtask
    task automatic t_filter();
        set_mode(2'h3, 1'b1);
        pulse();
        cur_check(6'h0C, 6'h03);
        pulse();
        cur_check(6'h0B, 6'h02);
    endtask
    task automatic t_fixed_modes();
        set_mode(2'h1, 1'b0);
        pulse();
        pulse();
        cur_check(6'h0C, 6'h03);
        check(16'(drv_on.act_code), 16'h000C);
        set_mode(2'h0, 1'b0);
        pulse();
        check(16'({drv_on.act_code, drv_on.act_sink}), 16'h0010);
        check(16'({drv_off.act_code, drv_off.act_sink}), 16'h0029);
    endtask
    task automatic t_disable();
        bridge_pwm_enable = 2'h0;
        pwm_input_pin = 1'b1;
        tick(4);
        check(16'(hb_drive[1]), {2'h0, CUR_HARD_OFF, 1'b1, CUR_HARD_OFF, 1'b1});
        pwm_input_pin = 1'b0;
    endtask
    initial begin
        tick(3);
        t_reset();
        nrst = 1'b1;
        tick(2);
        t_enable_hold();
        t_adapt();
        t_filter();
        t_fixed_modes();
        t_disable();
        tally_and_finish();
    end
endmodule // tb_top
